// >>> rtl/ofp_regs.sv
// Serial-bus register bank holding the frequency offset, output enable and pull range
// Behaviour
// - Bits 15:11 of the upper register read as zero and writes to them are dropped.
// - Bit 10 of the upper register is the software output enable, reset 0, 1 turns the driver on.
// - The software enable bit is written and used only in software enable mode, else the pin rules.
// - The 26-bit offset word is upper bits 9:0 above the 16-bit lower word.
// - All 26 offset bits reset to zero so the output starts at nominal.
// - The offset word is a signed two's-complement value.
// - A frequency change starts only on an upper write and applies the whole 26-bit word.
// - Bits 15:4 of the pull range register read as zero and writes to them are dropped.
// - Pull range code 3:0 selects sixteen half ranges from 6.25ppm up to 3200ppm.
// - The pull range code loads a factory value at reset and software may overwrite it.
// - Registers move as 16 bits, high byte first, with auto-incrementing register address.
module ofp_regs
  import ofp_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR      = 7'h60,  // Arbitrary default bus address
  parameter logic [3:0] FACTORY_RANGE = 4'h0    // Factory pull range code
) (
  // Clock, reset, enable
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire logic                 ce,
  // Serial bus pins
  input  wire logic                 scl_in,
  input  wire logic                 sda_in,
  output logic                      sda_out,
  output logic                      sda_oe,
  // Output enable control
  input  wire logic                 oe_sw_mode,
  input  wire logic                 oe_pin,
  output logic                      out_drive_en,
  // Oscillator control
  output logic signed [25:0]        freq_offset_word,
  output logic                      freq_update,
  output logic [3:0]                pull_range_code
);

  // Synchronisers and edge history
  logic             scl_m;
  logic             scl_s;
  logic             scl_d;
  logic             sda_m;
  logic             sda_s;
  logic             sda_d;
  logic             oe_pin_m;
  logic             oe_pin_s;

  // Engine and register state
  ofp_state_t       state;
  ofp_state_t       next_state;
  logic [3:0]       cnt;
  logic [3:0]       next_cnt;
  logic [7:0]       shift;
  logic [7:0]       next_shift;
  logic [7:0]       ptr;
  logic [7:0]       next_ptr;
  logic             hi;
  logic             next_hi;
  logic [7:0]       hold;
  logic [7:0]       next_hold;
  logic [15:0]      lower_offset_part;
  logic [15:0]      next_lower;
  logic [9:0]       upper_offset_part;
  logic [9:0]       next_upper;
  logic             oe_bit;
  logic             next_oe_bit;
  logic [25:0]      next_word;
  logic             next_update;
  logic [3:0]       next_range;
  logic             next_sda_oe;
  logic             next_drive;

  // Decoded bus events
  logic             scl_rise;
  logic             scl_fall;
  logic             bus_start;
  logic             bus_stop;
  logic [15:0]      rd_word;
  logic [7:0]       tx_byte;
  logic [15:0]      ahead_word;

  // Read view of a register; unmapped addresses and unused bits read zero
  function automatic logic [15:0] reg_read(input logic [7:0] a, input logic [15:0] lo,
                                           input logic [9:0] up, input logic oe,
                                           input logic [3:0] rng);
    logic [15:0] v;
    v = 16'h0000;
    case (a)
      OFP_REG_LOWER: v = lo;
      OFP_REG_UPPER: v = {5'h00, oe, up};
      OFP_REG_RANGE: v = {12'h000, rng};
      default:       v = 16'h0000;
    endcase
    return v;
  endfunction

  // Pins cross into the core clock through two flops before any use
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      scl_m    <= 1'b1;
      scl_s    <= 1'b1;
      scl_d    <= 1'b1;
      sda_m    <= 1'b1;
      sda_s    <= 1'b1;
      sda_d    <= 1'b1;
      oe_pin_m <= 1'b0;
      oe_pin_s <= 1'b0;
    end else if (ce) begin
      scl_m    <= scl_in;
      scl_s    <= scl_m;
      scl_d    <= scl_s;
      sda_m    <= sda_in;
      sda_s    <= sda_m;
      sda_d    <= sda_s;
      oe_pin_m <= oe_pin;
      oe_pin_s <= oe_pin_m;
    end
  end

  // Edge and condition detection works only on the second stage and later
  assign scl_rise  = scl_s & ~scl_d;
  assign scl_fall  = ~scl_s & scl_d;
  assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
  assign bus_stop  = scl_s & scl_d & ~sda_d & sda_s;
  assign rd_word   = reg_read(ptr, lower_offset_part, upper_offset_part, oe_bit, pull_range_code);
  assign tx_byte   = hi ? rd_word[15:8] : rd_word[7:0];
  // Word whose next byte goes out after a master ACK; a bit-select of a call result is not legal
  assign ahead_word = reg_read(hi ? ptr : ptr + 8'h01, lower_offset_part, upper_offset_part,
                               oe_bit, pull_range_code);

  // Next-state logic of the serial engine and the registers
  always_comb begin
    next_state  = state;
    next_cnt    = cnt;
    next_shift  = shift;
    next_ptr    = ptr;
    next_hi     = hi;
    next_hold   = hold;
    next_lower  = lower_offset_part;
    next_upper  = upper_offset_part;
    next_oe_bit = oe_bit;
    next_word   = freq_offset_word;
    next_update = 1'b0;
    next_range  = pull_range_code;
    next_sda_oe = sda_oe;
    next_drive  = oe_sw_mode ? oe_bit : oe_pin_s;
    if (bus_stop) begin
      next_state  = OFP_IDLE;
      next_sda_oe = 1'b0;
    end else if (bus_start) begin
      // Repeated start is handled like a fresh one
      next_state  = OFP_DEVADDR;
      next_cnt    = 4'h0;
      next_sda_oe = 1'b0;
    end else if (scl_rise) begin
      case (state)
        OFP_DEVADDR, OFP_REGADDR, OFP_WDATA, OFP_RDATA: begin
          next_shift = {shift[6:0], sda_s};
          next_cnt   = cnt + 4'h1;
        end
        OFP_RACK: begin
          // A master NACK ends the read; we wait for stop or start
          if (sda_s) begin
            next_state = OFP_IDLE;
          end
        end
        default: begin
          next_cnt = cnt;
        end
      endcase
    end else if (scl_fall) begin
      case (state)
        OFP_DEVADDR: begin
          if (cnt == 4'h8) begin
            if (shift[7:1] == DEV_ADDR) begin
              next_state  = OFP_DEVACK;
              next_sda_oe = 1'b1;
              next_hi     = 1'b1;
            end else begin
              next_state  = OFP_IDLE;                    // Address mismatch is NACKed
            end
          end
        end
        OFP_DEVACK: begin
          next_cnt = 4'h0;
          if (shift[0]) begin
            next_state  = OFP_RDATA;
            next_sda_oe = ~tx_byte[7];
          end else begin
            next_state  = OFP_REGADDR;
            next_sda_oe = 1'b0;
          end
        end
        OFP_REGADDR: begin
          if (cnt == 4'h8) begin
            next_ptr    = shift;
            next_hi     = 1'b1;
            next_state  = OFP_REGACK;
            next_sda_oe = 1'b1;
          end
        end
        OFP_REGACK, OFP_WACK: begin
          next_state  = OFP_WDATA;
          next_cnt    = 4'h0;
          next_sda_oe = 1'b0;
        end
        OFP_WDATA: begin
          if (cnt == 4'h8) begin
            next_state  = OFP_WACK;
            next_sda_oe = 1'b1;
            if (hi) begin
              next_hold = shift;
              next_hi   = 1'b0;
            end else begin
              next_hi  = 1'b1;
              next_ptr = ptr + 8'h01;
              case (ptr)
                OFP_REG_LOWER: begin
                  next_lower = {hold, shift};
                end
                OFP_REG_UPPER: begin
                  next_upper  = {hold[1:0], shift};
                  if (oe_sw_mode) begin
                    next_oe_bit = hold[OFP_OE_BIT - 8];
                  end
                  next_word   = {hold[1:0], shift, lower_offset_part};
                  next_update = 1'b1;
                end
                OFP_REG_RANGE: begin
                  next_range = shift[OFP_RANGE_MSB:0];
                end
                default: begin
                  next_ptr = ptr + 8'h01;
                end
              endcase
            end
          end
        end
        OFP_RDATA: begin
          if (cnt == 4'h8) begin
            next_state  = OFP_RACK;
            next_sda_oe = 1'b0;
          end else begin
            next_sda_oe = ~tx_byte[3'd7 - cnt[2:0]];
          end
        end
        OFP_RACK: begin
          // Master acknowledged: step to the next byte, advancing after the low byte
          next_cnt = 4'h0;
          next_hi  = ~hi;
          if (!hi) begin
            next_ptr = ptr + 8'h01;
          end
          next_state  = OFP_RDATA;
          next_sda_oe = ~(hi ? ahead_word[7] : ahead_word[15]);
        end
        default: begin
          next_sda_oe = 1'b0;
        end
      endcase
    end
  end

  // Registered state; outputs all leave from here
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state             <= OFP_IDLE;
      cnt               <= 4'h0;
      shift             <= 8'h00;
      ptr               <= 8'h00;
      hi                <= 1'b1;
      hold              <= 8'h00;
      lower_offset_part <= OFP_LOWER_RST;
      upper_offset_part <= OFP_UPPER_RST;
      oe_bit            <= OFP_OE_RST;
      freq_offset_word  <= OFP_WORD_RST;
      freq_update       <= 1'b0;
      pull_range_code   <= FACTORY_RANGE;
      sda_oe            <= 1'b0;
      sda_out           <= 1'b0;
      out_drive_en      <= 1'b0;
    end else if (ce) begin
      state             <= next_state;
      cnt               <= next_cnt;
      shift             <= next_shift;
      ptr               <= next_ptr;
      hi                <= next_hi;
      hold              <= next_hold;
      lower_offset_part <= next_lower;
      upper_offset_part <= next_upper;
      oe_bit            <= next_oe_bit;
      freq_offset_word  <= next_word;
      freq_update       <= next_update;
      pull_range_code   <= next_range;
      sda_oe            <= next_sda_oe;
      sda_out           <= 1'b0;                         // Open drain: only ever pulls low
      out_drive_en      <= next_drive;
    end
  end

endmodule

// >>> rtl/ofp_pkg.sv
// Register map, field layout and reset values of the oscillator pull control registers
package ofp_pkg;
  // Register indices on the serial bus
  localparam logic [7:0]  OFP_REG_LOWER     = 8'h00;
  localparam logic [7:0]  OFP_REG_UPPER     = 8'h01;
  localparam logic [7:0]  OFP_REG_RANGE     = 8'h02;
  // Field positions
  localparam int          OFP_OE_BIT        = 10;
  localparam int          OFP_UPPER_MSB     = 9;
  localparam int          OFP_RANGE_MSB     = 3;
  localparam int          OFP_WORD_W        = 26;
  localparam int          OFP_LOWER_W       = 16;
  // Reset values
  localparam logic [15:0] OFP_LOWER_RST     = 16'h0000;
  localparam logic [9:0]  OFP_UPPER_RST     = 10'h000;
  localparam logic        OFP_OE_RST        = 1'b0;
  localparam logic [25:0] OFP_WORD_RST      = 26'h0000000;
  // Serial engine states
  typedef enum logic [3:0] {
    OFP_IDLE,
    OFP_DEVADDR,
    OFP_DEVACK,
    OFP_REGADDR,
    OFP_REGACK,
    OFP_WDATA,
    OFP_WACK,
    OFP_RDATA,
    OFP_RACK
  } ofp_state_t;
endpackage

// >>> dv/ofp_regs_props.sv
// Assertion checker for the pull control register bank
module ofp_regs_props
  import ofp_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR      = 7'h60,
  parameter logic [3:0] FACTORY_RANGE = 4'h0
) (
  // Clock, reset, enable
  input wire logic               core_clk,
  input wire logic               rst_n,
  input wire logic               ce,
  // Serial bus pins
  input wire logic               scl_in,
  input wire logic               sda_in,
  input wire logic               sda_out,
  input wire logic               sda_oe,
  // Output enable control
  input wire logic               oe_sw_mode,
  input wire logic               oe_pin,
  input wire logic               out_drive_en,
  // Oscillator control
  input wire logic signed [25:0] freq_offset_word,
  input wire logic               freq_update,
  input wire logic [3:0]         pull_range_code
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Reset state must show in the first cycle after release
  a_rst_offset: assert property ($rose(rst_n) |-> freq_offset_word == OFP_WORD_RST)
    else $error("offset not cleared by reset");
  a_rst_range: assert property ($rose(rst_n) |-> pull_range_code == FACTORY_RANGE)
    else $error("range code not factory value");
  a_rst_drive: assert property ($rose(rst_n) |-> !out_drive_en)
    else $error("driver on after reset");
  // Staged lower words must stay hidden until the pulse
  a_word_commit: assert property ($changed(freq_offset_word) |-> freq_update)
    else $error("offset moved without update");
  a_update_pulse: assert property (freq_update |=> !freq_update)
    else $error("update pulse too long");
  // Four settled cycles cover the pin sync and the output flop
  a_pin_follow: assert property ((ce && !oe_sw_mode && $stable(oe_pin)) [*4] |-> out_drive_en == oe_pin)
    else $error("driver not following pin");
  a_sw_hold: assert property ($past(oe_sw_mode) && $past(oe_sw_mode, 2) && $changed(out_drive_en) |-> $past(freq_update))
    else $error("software enable moved without upper write");
  // Device only starts pulling data while the bus clock is low
  a_ack_timing: assert property ($rose(sda_oe) |-> !$past(scl_in, 2))
    else $error("data pulled during clock high");
endmodule

bind ofp_regs ofp_regs_props #(.DEV_ADDR(DEV_ADDR), .FACTORY_RANGE(FACTORY_RANGE)) ofp_regs_props_inst (
  .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .oe_sw_mode(oe_sw_mode), .oe_pin(oe_pin), .out_drive_en(out_drive_en),
  .freq_offset_word(freq_offset_word), .freq_update(freq_update), .pull_range_code(pull_range_code));

// >>> dv/ofp_host.sv
// Serial bus master model that reaches the register bank
module ofp_host (
  // Clock
  input  wire logic core_clk,
  // Bus lines
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl = 1'h1;
    sda_pull = 1'h0;
  end
  // Wait n core cycles, then act just after the edge
  task automatic hp(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Start or repeated start; data is released mid low phase, then pulled low while the clock is high
  task automatic st();
    hp(4);
    sda_pull = 1'h0;
    hp(4);
    scl = 1'h1;
    hp(8);
    sda_pull = 1'h1;
    hp(8);
    scl = 1'h0;
  endtask
  task automatic sp();
    hp(4);
    sda_pull = 1'h1;
    hp(4);
    scl = 1'h1;
    hp(8);
    sda_pull = 1'h0;
    hp(8);
  endtask
  // Byte MSB first then ack slot; 16-cycle bits keep updates far below 38 kHz
  task automatic xb(input logic [8:0] v, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      hp(4);
      sda_pull = !v[i];
      hp(4);
      scl = 1'h1;
      hp(8);
      r[i] = sda;
      scl = 1'h0;
    end
  endtask
endmodule

// >>> dv/ofp_regs_tb_top.sv
// Self-checking bench for the pull control register bank
module ofp_regs_tb_top
  import ofp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [6:0] DEV  = 7'h60;  // Arbitrary bus address
  localparam logic [3:0] FRNG = 4'h9;   // Off zero so the reset load is visible
  logic               core_clk, rst_n, ce, scl, sda_pull, sda_oe, sda_out;
  logic               oe_sw_mode, oe_pin, out_drive_en, freq_update;
  logic signed [25:0] freq_offset_word;
  logic [3:0]         pull_range_code;
  logic [15:0]        w;
  int                 mismatches, comparisons, p;
  int                 pulses = 0;
  wire                sda = !(sda_pull || (sda_oe && !sda_out));  // Pulled up unless held low
  ofp_regs #(.DEV_ADDR(DEV), .FACTORY_RANGE(FRNG)) ofp_regs_inst (
    .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .oe_sw_mode(oe_sw_mode), .oe_pin(oe_pin), .out_drive_en(out_drive_en),
    .freq_offset_word(freq_offset_word), .freq_update(freq_update), .pull_range_code(pull_range_code));
  ofp_host ofp_host_inst (.core_clk(core_clk), .scl(scl), .sda_pull(sda_pull), .sda(sda));
  initial begin
    core_clk = 1'h0;
    forever #50 core_clk = !core_clk;
  end
  // Count update pulses so each write is judged by how many it caused
  always @(posedge core_clk) if (freq_update === 1'h1) pulses++;
  task automatic chk(input string n, input logic [25:0] e, input logic [25:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // Write n words of d, high word first, with one register address
  task automatic wr(input logic [7:0] a, input int n, input logic [31:0] d);
    logic [8:0] r;
    ofp_host_inst.st();
    ofp_host_inst.xb({DEV, 1'h0, 1'h1}, r);
    chk("addr ack", 26'h0, r[0]);
    ofp_host_inst.xb({a, 1'h1}, r);
    for (int i = 2 * n - 1; i >= 0; i--) begin
      ofp_host_inst.xb({d[8*i +: 8], 1'h1}, r);
    end
    ofp_host_inst.sp();
  endtask
  task automatic rd(input logic [7:0] a);
    logic [8:0] r, s;
    ofp_host_inst.st();
    ofp_host_inst.xb({DEV, 1'h0, 1'h1}, r);
    ofp_host_inst.xb({a, 1'h1}, r);
    ofp_host_inst.st();
    ofp_host_inst.xb({DEV, 1'h1, 1'h1}, r);
    ofp_host_inst.xb({8'hFF, 1'h0}, r);
    ofp_host_inst.xb({8'hFF, 1'h1}, s);  // Master refusal ends the read
    ofp_host_inst.sp();
    w = {r[8:1], s[8:1]};
  endtask
  task automatic t_reset();
    chk("offset", 26'h0, freq_offset_word);
    chk("range", FRNG, pull_range_code);
    chk("drive", 26'h0, out_drive_en);
    rd(OFP_REG_UPPER);
    chk("upper reg", 26'h0, w);
  endtask
  // Plus 90 of 200: lower stays staged until the upper word lands
  task automatic t_commit();
    p = pulses;
    wr(OFP_REG_LOWER, 1, 32'h6666);
    chk("staged", 26'h0, freq_offset_word);
    chk("pulses", p, pulses);
    wr(OFP_REG_UPPER, 1, 32'hFCE6);
    chk("offset", 26'h0E66666, freq_offset_word);
    chk("pulses", p + 1, pulses);
    chk("drive", 26'h1, out_drive_en);
    rd(OFP_REG_UPPER);
    chk("upper reg", 26'h04E6, w);
    wr(OFP_REG_LOWER, 2, 32'h00000380);
    chk("neg offset", 26'h3800000, freq_offset_word);
    chk("drive", 26'h0, out_drive_en);
  endtask
  // Pin mode ignores the software bit, even after returning
  task automatic t_pin();
    oe_sw_mode = 1'h0;
    oe_pin = 1'h1;
    ofp_host_inst.hp(6);
    chk("pin drive", 26'h1, out_drive_en);
    oe_pin = 1'h0;
    wr(OFP_REG_UPPER, 1, 32'h0400);
    chk("pin drive", 26'h0, out_drive_en);
    // A low enable must freeze the pin path; then the pin level differs from the kept software bit
    ce = 1'h0;
    oe_pin = 1'h1;
    ofp_host_inst.hp(6);
    chk("frozen drive", 26'h0, out_drive_en);
    ce = 1'h1;
    ofp_host_inst.hp(6);
    chk("pin drive", 26'h1, out_drive_en);
    oe_sw_mode = 1'h1;
    ofp_host_inst.hp(6);
    chk("sw drive", 26'h0, out_drive_en);
  endtask
  task automatic t_range();
    for (int c = 0; c < 16; c++) begin
      wr(OFP_REG_RANGE, 1, {28'hFFFFFFF, c[3:0]});
      rd(OFP_REG_RANGE);
      chk("range reg", c[3:0], w);
      chk("range", c[3:0], pull_range_code);
    end
  endtask
  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    rst_n = 1'h0;
    ce = 1'h1;
    oe_sw_mode = 1'h1;
    oe_pin = 1'h0;
    ofp_host_inst.hp(10);
    rst_n = 1'h1;
    ofp_host_inst.hp(3);
    t_reset();
    t_commit();
    t_pin();
    t_range();
    stop_test();
  end
  // Roughly forty transfers under a thousand cycles each fit well inside this
  initial begin
    ofp_host_inst.hp(90000);
    mismatches++;
    stop_test();
  end
endmodule
